// File: ppmr_defs.vh
`ifndef PPMR_DEFS_VH
`define PPMR_DEFS_VH

// Serial bus address, upper seven bits of 0xAC
`define PPMR_DEV_ADDR      7'h56

// Register offsets
`define PPMR_REG_CTRL      8'h00
`define PPMR_REG_ADV       8'h04
`define PPMR_REG_GIG       8'h09
`define PPMR_REG_PAGE      8'h16
`define PPMR_REG_GSTAT     8'h17
`define PPMR_REG_LEDC      8'h18
`define PPMR_REG_LEDO      8'h19
`define PPMR_REG_EXT2      8'h1A
`define PPMR_REG_HIMODE    8'h1B
`define PPMR_REG_DIAG      8'h1C
`define PPMR_REG_EXTM      8'h1D
`define PPMR_REG_PAGED     8'h1E

// Page selector values
`define PPMR_PG_COPPER     16'h0000
`define PPMR_PG_FIBER      16'h0001
`define PPMR_PG_CAL        16'h0003
`define PPMR_PG_DIAG       16'h0004
`define PPMR_PG_FGIG       16'h0007
`define PPMR_PG_CLSA       16'h000B
`define PPMR_PG_CRC        16'h000C
`define PPMR_PG_TEST       16'h0010
`define PPMR_PG_MISC       16'h0012

// Reset values
`define PPMR_CTRL_RST      16'h1140
`define PPMR_ADV_RST       16'h0DE1
`define PPMR_GIG_RST       16'h0200
`define PPMR_ZERO_RST      16'h0000
`define PPMR_ACT_GIG_RST   2'h2
`define PPMR_ACT_LOW_RST   4'hF
`define PPMR_ACT_SPD_RST   2'h2
`define PPMR_MODE_RST      4'h0

// Field positions
`define PPMR_CTRL_RESET_BIT 15
`define PPMR_CTRL_SPDL_BIT  13
`define PPMR_CTRL_AN_BIT    12
`define PPMR_CTRL_DUP_BIT   8
`define PPMR_CTRL_SPDM_BIT  6
`define PPMR_GIG_HI         9
`define PPMR_GIG_LO         8
`define PPMR_ADV_HI         8
`define PPMR_ADV_LO         5
`define PPMR_MODE_HI        3
`define PPMR_MODE_LO        0

// Host interface mode code for SGMII without clocks
`define PPMR_MODE_SGMII    4'h4

`endif

// File: ppmr_host_model.sv
`timescale 1ns/1ps
module ppmr_host_model (
  input  wire i_clk,
  input  wire i_sda,
  output reg  o_scl,
  output reg  o_sda
);
  integer i;
  reg     a;
  initial begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end
  // Four cycles a phase, above the three-cycle floor
  task ph;
    repeat (4) @(negedge i_clk);
  endtask
  // Also used as repeated start
  task start;
    begin
      o_sda = 1'b1;
      ph;
      o_scl = 1'b1;
      ph;
      o_sda = 1'b0;
      ph;
      o_scl = 1'b0;
    end
  endtask
  task stop;
    begin
      o_sda = 1'b0;
      ph;
      o_scl = 1'b1;
      ph;
      o_sda = 1'b1;
      ph;
    end
  endtask
  task xfer(input b, output r);
    begin
      o_sda = b;
      ph;
      o_scl = 1'b1;
      ph;
      r = i_sda;
      o_scl = 1'b0;
    end
  endtask
  task send8(input [7:0] d, output k);
    begin
      for (i = 7; i >= 0; i = i - 1)
        xfer(d[i], a);
      xfer(1'b1, k);
    end
  endtask
  task get8(input m, output [7:0] d);
    begin
      for (i = 7; i >= 0; i = i - 1)
        xfer(1'b1, d[i]);
      xfer(m, a);
    end
  endtask
  task wr(input [7:0] dev, input [7:0] r, input [15:0] d, output nak);
    reg k0, k1, k2, k3;
    begin
      start;
      send8(dev, k0);
      send8(r, k1);
      send8(d[15:8], k2);
      send8(d[7:0], k3);
      stop;
      nak = k0 | k1 | k2 | k3;
    end
  endtask
  // stop after the high byte only
  task wrh(input [7:0] r, input [7:0] h);
    begin
      start;
      send8(8'hAC, a);
      send8(r, a);
      send8(h, a);
      stop;
    end
  endtask
  task rd(input [7:0] r, output [15:0] d);
    begin
      start;
      send8(8'hAC, a);
      send8(r, a);
      start;
      send8(8'hAD, a);
      get8(1'b0, d[15:8]);
      get8(1'b1, d[7:0]);
      stop;
    end
  endtask
endmodule // ppmr_host_model

// File: ppmr_paged_phy_mgmt_regs.v
`timescale 1ns/1ps
`include "ppmr_defs.vh"
module ppmr_paged_phy_mgmt_regs (
  input  wire        i_sys_clk,
  input  wire        i_resetn,
  input  wire        i_scl,
  input  wire        i_sda,
  output reg         o_sda_out,
  output reg         o_sda_oe,
  input  wire [15:0] i_global_status,
  input  wire [15:0] i_media_pairs_status,
  input  wire [15:0] i_crc_result,
  output reg         o_sgmii_mode,
  output reg         o_autoneg_en,
  output reg         o_full_duplex,
  output reg  [1:0]  o_speed_sel,
  output reg  [1:0]  o_adv_gig,
  output reg  [3:0]  o_adv_low,
  output reg         o_sw_reset,
  output reg  [15:0] o_page
);
  localparam [2:0] ST_IDLE = 3'd0;
  localparam [2:0] ST_RX   = 3'd1;
  localparam [2:0] ST_ACK  = 3'd2;
  localparam [2:0] ST_TX   = 3'd3;
  localparam [2:0] ST_MACK = 3'd4;
  localparam [1:0] PH_DEV  = 2'd0;
  localparam [1:0] PH_REG  = 2'd1;
  localparam [1:0] PH_WHI  = 2'd2;
  localparam [1:0] PH_WLO  = 2'd3;

  reg        scl_q;
  reg        sda_q;
  reg [2:0]  state_q;
  reg [1:0]  phase_q;
  reg [3:0]  bit_cnt_q;
  reg [7:0]  sr_q;
  reg [7:0]  tx_q;
  reg        rw_q;
  reg        hi_q;
  reg        nack_q;
  reg [7:0]  reg_ptr_q;
  reg [7:0]  wdata_hi_q;
  reg        wr_q;
  reg [15:0] wr_data_q;
  reg [15:0] rd_word_q;
  reg [15:0] rd_mux;

  wire [15:0] ctl0_q, ctl1_q, adv0_q, adv1_q;
  wire [15:0] gig_q, page_q, ledc_q, ledo_q;
  wire [15:0] ext2_q, himode_q, extm_q, cal_q;
  wire [15:0] fgig_q, clsa_q, test_q, misc_q;

  // Bus events; pins are already in the clock domain
  wire scl_rise = i_scl & ~scl_q;
  wire scl_fall = ~i_scl & scl_q;
  wire bus_start = scl_q & i_scl & sda_q & ~i_sda;
  wire bus_stop = scl_q & i_scl & ~sda_q & i_sda;

  wire pg_fiber = (page_q == `PPMR_PG_FIBER);
  wire pg_copper = ~pg_fiber;
  wire wr_at = wr_q;
  wire [15:0] ctl_wdata = {1'b0, wr_data_q[14:0]};
  wire we_ctl0 = wr_at & (reg_ptr_q == `PPMR_REG_CTRL) & pg_copper;
  wire we_ctl1 = wr_at & (reg_ptr_q == `PPMR_REG_CTRL) & pg_fiber;
  wire we_adv0 = wr_at & (reg_ptr_q == `PPMR_REG_ADV) & pg_copper;
  wire we_adv1 = wr_at & (reg_ptr_q == `PPMR_REG_ADV) & pg_fiber;
  wire we_gig = wr_at & (reg_ptr_q == `PPMR_REG_GIG);
  wire we_page = wr_at & (reg_ptr_q == `PPMR_REG_PAGE);
  wire we_ledc = wr_at & (reg_ptr_q == `PPMR_REG_LEDC);
  wire we_ledo = wr_at & (reg_ptr_q == `PPMR_REG_LEDO);
  wire we_ext2 = wr_at & (reg_ptr_q == `PPMR_REG_EXT2);
  wire we_himode = wr_at & (reg_ptr_q == `PPMR_REG_HIMODE);
  wire we_extm = wr_at & (reg_ptr_q == `PPMR_REG_EXTM);
  wire we_r30 = wr_at & (reg_ptr_q == `PPMR_REG_PAGED);
  wire we_cal = we_r30 & (page_q == `PPMR_PG_CAL);
  wire we_fgig = we_r30 & (page_q == `PPMR_PG_FGIG);
  wire we_clsa = we_r30 & (page_q == `PPMR_PG_CLSA);
  wire we_test = we_r30 & (page_q == `PPMR_PG_TEST);
  wire we_misc = we_r30 & (page_q == `PPMR_PG_MISC);
  wire sw_rst = wr_at & (reg_ptr_q == `PPMR_REG_CTRL) & wr_data_q[`PPMR_CTRL_RESET_BIT];

  // Reset bit self-clears, so it is never stored
  ppmr_reg16 #(.RST(`PPMR_CTRL_RST)) u_ctl0 (
    .i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .i_we(we_ctl0), .i_wdata(ctl_wdata),
    .o_q(ctl0_q));
  ppmr_reg16 #(.RST(`PPMR_CTRL_RST)) u_ctl1 (
    .i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .i_we(we_ctl1), .i_wdata(ctl_wdata),
    .o_q(ctl1_q));
  ppmr_reg16 #(.RST(`PPMR_ADV_RST)) u_adv0 (
    .i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .i_we(we_adv0), .i_wdata(wr_data_q),
    .o_q(adv0_q));
  ppmr_reg16 #(.RST(`PPMR_ADV_RST)) u_adv1 (
    .i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .i_we(we_adv1), .i_wdata(wr_data_q),
    .o_q(adv1_q));
  ppmr_reg16 #(.RST(`PPMR_GIG_RST)) u_gig (
    .i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .i_we(we_gig), .i_wdata(wr_data_q),
    .o_q(gig_q));
  ppmr_reg16 #(.RST(`PPMR_ZERO_RST)) u_page (
    .i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .i_we(we_page), .i_wdata(wr_data_q),
    .o_q(page_q));
  ppmr_reg16 #(.RST(`PPMR_ZERO_RST)) u_ledc (
    .i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .i_we(we_ledc), .i_wdata(wr_data_q),
    .o_q(ledc_q));
  ppmr_reg16 #(.RST(`PPMR_ZERO_RST)) u_ledo (
    .i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .i_we(we_ledo), .i_wdata(wr_data_q),
    .o_q(ledo_q));
  ppmr_reg16 #(.RST(`PPMR_ZERO_RST)) u_ext2 (
    .i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .i_we(we_ext2), .i_wdata(wr_data_q),
    .o_q(ext2_q));
  ppmr_reg16 #(.RST(`PPMR_ZERO_RST)) u_himode (
    .i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .i_we(we_himode), .i_wdata(wr_data_q),
    .o_q(himode_q));
  ppmr_reg16 #(.RST(`PPMR_ZERO_RST)) u_extm (
    .i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .i_we(we_extm), .i_wdata(wr_data_q),
    .o_q(extm_q));
  ppmr_reg16 #(.RST(`PPMR_ZERO_RST)) u_cal (
    .i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .i_we(we_cal), .i_wdata(wr_data_q),
    .o_q(cal_q));
  ppmr_reg16 #(.RST(`PPMR_ZERO_RST)) u_fgig (
    .i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .i_we(we_fgig), .i_wdata(wr_data_q),
    .o_q(fgig_q));
  ppmr_reg16 #(.RST(`PPMR_ZERO_RST)) u_clsa (
    .i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .i_we(we_clsa), .i_wdata(wr_data_q),
    .o_q(clsa_q));
  ppmr_reg16 #(.RST(`PPMR_ZERO_RST)) u_test (
    .i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .i_we(we_test), .i_wdata(wr_data_q),
    .o_q(test_q));
  ppmr_reg16 #(.RST(`PPMR_ZERO_RST)) u_misc (
    .i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .i_we(we_misc), .i_wdata(wr_data_q),
    .o_q(misc_q));

  // Read mux; unmapped offsets read zero
  always @* begin
    rd_mux = 16'h0000;
    case (reg_ptr_q)
      `PPMR_REG_CTRL:   rd_mux = pg_fiber ? ctl1_q : ctl0_q;
      `PPMR_REG_ADV:    rd_mux = pg_fiber ? adv1_q : adv0_q;
      `PPMR_REG_GIG:    rd_mux = gig_q;
      `PPMR_REG_PAGE:   rd_mux = page_q;
      `PPMR_REG_GSTAT:  rd_mux = i_global_status;
      `PPMR_REG_LEDC:   rd_mux = ledc_q;
      `PPMR_REG_LEDO:   rd_mux = ledo_q;
      `PPMR_REG_EXT2:   rd_mux = ext2_q;
      `PPMR_REG_HIMODE: rd_mux = himode_q;
      // Pair status on page 4 only
      `PPMR_REG_DIAG:   rd_mux = (page_q == `PPMR_PG_DIAG) ? i_media_pairs_status : 16'h0000;
      `PPMR_REG_EXTM:   rd_mux = extm_q;
      `PPMR_REG_PAGED: begin
        case (page_q)
          `PPMR_PG_CAL:  rd_mux = cal_q;
          `PPMR_PG_FGIG: rd_mux = fgig_q;
          `PPMR_PG_CLSA: rd_mux = clsa_q;
          `PPMR_PG_CRC:  rd_mux = i_crc_result;
          `PPMR_PG_TEST: rd_mux = test_q;
          `PPMR_PG_MISC: rd_mux = misc_q;
          default:       rd_mux = 16'h0000;
        endcase
      end
      default: rd_mux = 16'h0000;
    endcase
  end

  // Two-wire slave engine
  always @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      scl_q      <= 1'b1;
      sda_q      <= 1'b1;
      state_q    <= ST_IDLE;
      phase_q    <= PH_DEV;
      bit_cnt_q  <= 4'h0;
      sr_q       <= 8'h00;
      tx_q       <= 8'h00;
      rw_q       <= 1'b0;
      hi_q       <= 1'b1;
      nack_q     <= 1'b0;
      reg_ptr_q  <= 8'h00;
      wdata_hi_q <= 8'h00;
      wr_q       <= 1'b0;
      wr_data_q  <= 16'h0000;
      rd_word_q  <= 16'h0000;
      o_sda_oe   <= 1'b0;
      o_sda_out  <= 1'b0;
    end else begin
      scl_q <= i_scl;
      sda_q <= i_sda;
      wr_q  <= 1'b0;
      if (bus_start) begin
        state_q   <= ST_RX;
        phase_q   <= PH_DEV;
        bit_cnt_q <= 4'h0;
        rw_q      <= 1'b0;
        o_sda_oe  <= 1'b0;
      end else if (bus_stop) begin
        state_q  <= ST_IDLE;
        o_sda_oe <= 1'b0;
      end else begin
        case (state_q)
          ST_IDLE: begin
            o_sda_oe <= 1'b0;
          end
          ST_RX: begin
            if (scl_rise) begin
              sr_q      <= {sr_q[6:0], i_sda};
              bit_cnt_q <= bit_cnt_q + 4'h1;
            end else if (scl_fall && bit_cnt_q == 4'h8) begin
              state_q  <= ST_ACK;
              o_sda_oe <= 1'b1;
              case (phase_q)
                PH_DEV: begin
                  if (sr_q[7:1] == `PPMR_DEV_ADDR) begin
                    rw_q      <= sr_q[0];
                    hi_q      <= 1'b1;
                    rd_word_q <= rd_mux;
                    phase_q   <= PH_REG;
                  end else begin
                    state_q  <= ST_IDLE;
                    o_sda_oe <= 1'b0;
                  end
                end
                PH_REG: begin
                  reg_ptr_q <= sr_q;
                  phase_q   <= PH_WHI;
                end
                PH_WHI: begin
                  wdata_hi_q <= sr_q;
                  phase_q    <= PH_WLO;
                end
                PH_WLO: begin
                  wr_q      <= 1'b1;
                  wr_data_q <= {wdata_hi_q, sr_q};
                  phase_q   <= PH_WHI;
                end
                default: phase_q <= PH_DEV;
              endcase
            end
          end
          ST_ACK: begin
            if (scl_fall) begin
              bit_cnt_q <= 4'h0;
              if (rw_q) begin
                tx_q     <= rd_word_q[15:8];
                o_sda_oe <= ~rd_word_q[15];
                state_q  <= ST_TX;
              end else begin
                o_sda_oe <= 1'b0;
                state_q  <= ST_RX;
              end
            end
          end
          ST_TX: begin
            if (scl_fall) begin
              if (bit_cnt_q == 4'h7) begin
                o_sda_oe <= 1'b0;
                state_q  <= ST_MACK;
              end else begin
                o_sda_oe  <= ~tx_q[6];
                tx_q      <= {tx_q[6:0], 1'b0};
                bit_cnt_q <= bit_cnt_q + 4'h1;
              end
            end
          end
          ST_MACK: begin
            if (scl_rise) begin
              nack_q <= i_sda;
            end else if (scl_fall) begin
              if (nack_q) begin
                state_q <= ST_IDLE;
              end else begin
                // Bytes alternate high then low
                hi_q      <= ~hi_q;
                tx_q      <= hi_q ? rd_word_q[7:0] : rd_word_q[15:8];
                o_sda_oe  <= hi_q ? ~rd_word_q[7] : ~rd_word_q[15];
                bit_cnt_q <= 4'h0;
                state_q   <= ST_TX;
              end
            end
          end
          default: state_q <= ST_IDLE;
        endcase
      end
    end
  end

  // Applied configuration; mode, duplex, speed and adverts update only on software reset, autoneg and page every cycle
  always @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_sgmii_mode  <= 1'b0;
      o_full_duplex <= 1'b1;
      o_speed_sel   <= `PPMR_ACT_SPD_RST;
      o_adv_gig     <= `PPMR_ACT_GIG_RST;
      o_adv_low     <= `PPMR_ACT_LOW_RST;
      o_autoneg_en  <= 1'b1;
      o_sw_reset    <= 1'b0;
      o_page        <= 16'h0000;
    end else begin
      o_sw_reset <= sw_rst;
      o_page     <= page_q;
      // Either control copy can stop negotiation at once
      o_autoneg_en <= ctl0_q[`PPMR_CTRL_AN_BIT] & ctl1_q[`PPMR_CTRL_AN_BIT];
      // Last reset picks up mode and adverts
      if (sw_rst) begin
        o_sgmii_mode  <= (himode_q[`PPMR_MODE_HI:`PPMR_MODE_LO] == `PPMR_MODE_SGMII);
        o_full_duplex <= wr_data_q[`PPMR_CTRL_DUP_BIT];
        o_speed_sel   <= {wr_data_q[`PPMR_CTRL_SPDM_BIT], wr_data_q[`PPMR_CTRL_SPDL_BIT]};
        o_adv_gig     <= gig_q[`PPMR_GIG_HI:`PPMR_GIG_LO];
        o_adv_low     <= adv0_q[`PPMR_ADV_HI:`PPMR_ADV_LO];
      end
    end
  end

endmodule // ppmr_paged_phy_mgmt_regs

// File: ppmr_props.sv
`timescale 1ns/1ps
module ppmr_props (
  input wire        i_sys_clk,
  input wire        i_resetn,
  input wire        i_scl,
  input wire        i_sda,
  input wire        o_sda_out,
  input wire        o_sda_oe,
  input wire [15:0] i_global_status,
  input wire [15:0] i_media_pairs_status,
  input wire [15:0] i_crc_result,
  input wire        o_sgmii_mode,
  input wire        o_autoneg_en,
  input wire        o_full_duplex,
  input wire [1:0]  o_speed_sel,
  input wire [1:0]  o_adv_gig,
  input wire [3:0]  o_adv_low,
  input wire        o_sw_reset,
  input wire [15:0] o_page
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_resetn);

  sw_pulse_a: assert property (o_sw_reset |=> !o_sw_reset [*8])
    else $error("software reset pulse too long");
  reset_on_ack_a: assert property (o_sw_reset |-> o_sda_oe)
    else $error("software reset outside a write");
  mode_apply_a: assert property ($changed(o_sgmii_mode) |-> o_sw_reset || $past(o_sw_reset))
    else $error("host mode changed without software reset");
  adv_apply_a: assert property ($changed({o_adv_gig, o_adv_low}) |->
    o_sw_reset || $past(o_sw_reset)) else $error("advert changed without software reset");
  speed_apply_a: assert property ($changed({o_full_duplex, o_speed_sel}) |->
    o_sw_reset || $past(o_sw_reset)) else $error("speed changed without software reset");
  page_on_ack_a: assert property ($changed(o_page) |-> o_sda_oe)
    else $error("page changed outside a write");
  an_on_ack_a: assert property ($changed(o_autoneg_en) |-> o_sda_oe && $past(o_sda_oe))
    else $error("autoneg changed outside a write");
  ack_scl_low_a: assert property ($rose(o_sda_oe) |-> !i_scl)
    else $error("data driven while clock high");
  oe_hold_a: assert property (i_scl && $past(i_scl) |-> $stable(o_sda_oe))
    else $error("data moved while clock high");
endmodule // ppmr_props

bind ppmr_paged_phy_mgmt_regs ppmr_props i_ppmr_props (
  .i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .i_scl(i_scl), .i_sda(i_sda),
  .o_sda_out(o_sda_out), .o_sda_oe(o_sda_oe), .i_global_status(i_global_status),
  .i_media_pairs_status(i_media_pairs_status), .i_crc_result(i_crc_result),
  .o_sgmii_mode(o_sgmii_mode), .o_autoneg_en(o_autoneg_en), .o_full_duplex(o_full_duplex),
  .o_speed_sel(o_speed_sel), .o_adv_gig(o_adv_gig), .o_adv_low(o_adv_low),
  .o_sw_reset(o_sw_reset), .o_page(o_page));

// File: ppmr_reg16.v
`timescale 1ns/1ps
module ppmr_reg16 #(
  parameter [15:0] RST = 16'h0000
) (
  input  wire        i_sys_clk,
  input  wire        i_resetn,
  input  wire        i_we,
  input  wire [15:0] i_wdata,
  output reg  [15:0] o_q
);
  always @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_q <= RST;
    end else if (i_we) begin
      o_q <= i_wdata;
    end
  end
endmodule // ppmr_reg16

// File: tb_ppmr_paged_phy_mgmt_regs.sv
`timescale 1ns/1ps
module tb_ppmr_paged_phy_mgmt_regs;
  localparam [79:0] PGS = {16'h0012, 16'h0010, 16'h000B, 16'h0007, 16'h0003};
  reg         clk = 1'b0;
  reg         rstn = 1'b0;
  reg  [15:0] gstat = 16'h0000;
  reg  [15:0] pairs = 16'h0000;
  reg  [15:0] crc = 16'h0000;
  wire        scl, msda, sdo, oe, sgmii, an, fd, swr;
  wire [1:0]  spd, agig;
  wire [3:0]  alow;
  wire [15:0] page;
  wire        sda = (oe ? sdo : 1'b1) & msda;
  integer     errors = 0;
  integer     swn = 0;
  integer     seed = 32'h25A27640;
  integer     samples_checked = 0;
  integer     cyc = 0;
  integer     i;
  reg  [15:0] rv, wv;
  reg  [15:0] pv [0:4];
  reg         ack;
  always #20 clk = ~clk;
  ppmr_paged_phy_mgmt_regs i_ppmr_paged_phy_mgmt_regs (
    .i_sys_clk(clk), .i_resetn(rstn), .i_scl(scl), .i_sda(sda), .o_sda_out(sdo),
    .o_sda_oe(oe), .i_global_status(gstat), .i_media_pairs_status(pairs),
    .i_crc_result(crc), .o_sgmii_mode(sgmii), .o_autoneg_en(an), .o_full_duplex(fd),
    .o_speed_sel(spd), .o_adv_gig(agig), .o_adv_low(alow), .o_sw_reset(swr), .o_page(page));
  ppmr_host_model i_ppmr_host_model (.i_clk(clk), .i_sda(sda), .o_scl(scl), .o_sda(msda));
  task chk(input [15:0] got, input [15:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (got !== exp) begin
        errors = errors + 1;
        $display("BAD %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task close_out;
    begin
      if (errors == 0 && samples_checked > 0)
        $display("DONE - PASS");
      else
        $display("DONE - FAIL");
      $finish;
    end
  endtask
  task w(input [7:0] r, input [15:0] d);
    begin
      i_ppmr_host_model.wr(8'hAC, r, d, ack);
      chk(ack, 1'b0);
    end
  endtask
  task rdc(input [7:0] r, input [15:0] e);
    begin
      i_ppmr_host_model.rd(r, rv);
      chk(rv, e);
    end
  endtask
  initial begin
    rv = $urandom(seed);
    repeat (5) @(negedge clk);
    rstn = 1'b1;
    repeat (3) @(negedge clk);
    chk({sgmii, fd, spd, agig, alow, an}, {1'b0, 1'b1, 2'h2, 2'h2, 4'hF, 1'b1});
    rdc(8'h00, 16'h1140);
    rdc(8'h1B, 16'h0000);
    i_ppmr_host_model.wr(8'hAE, 8'h18, 16'h1234, ack);
    chk(ack, 1'b1);
    rdc(8'h18, 16'h0000);
    i_ppmr_host_model.wrh(8'h18, 8'hA5);
    rdc(8'h18, 16'h0000);
    w(8'h1B, 16'h9084);
    chk(sgmii, 1'b0);
    w(8'h00, 16'h9140);
    chk(sgmii, 1'b1);
    w(8'h16, 16'h0000);
    w(8'h09, 16'h0F00);
    w(8'h04, 16'h0DE1);
    chk(agig, 2'h2);
    w(8'h00, 16'h9140);
    chk({agig, alow, fd, spd}, {2'h3, 4'hF, 1'b1, 2'h2});
    rdc(8'h09, 16'h0F00);
    for (i = 0; i < 4; i = i + 1) begin
      wv = $urandom;
      w(8'h04, wv);
      w(8'h00, wv | 16'h8000);
      chk({alow, fd, spd, an}, {wv[8:5], wv[8], wv[6], wv[13], wv[12]});
      rdc(8'h00, wv & 16'h7FFF);
    end
    w(8'h00, 16'h9140);
    for (i = 0; i < 5; i = i + 1) begin
      pv[i] = $urandom;
      w(8'h16, PGS[16*i +: 16]);
      w(8'h1E, pv[i]);
    end
    for (i = 0; i < 5; i = i + 1) begin
      w(8'h16, PGS[16*i +: 16]);
      rdc(8'h1E, pv[i]);
    end
    crc = $urandom;
    w(8'h16, 16'h000C);
    w(8'h1E, ~crc);
    rdc(8'h1E, crc);
    pairs = $urandom;
    w(8'h16, 16'h0004);
    chk(page, 16'h0004);
    rdc(8'h1C, pairs);
    w(8'h16, 16'h0000);
    rdc(8'h1C, 16'h0000);
    gstat = $urandom;
    w(8'h17, ~gstat);
    rdc(8'h17, gstat);
    w(8'h16, 16'h0001);
    chk(page, 16'h0001);
    rdc(8'h04, 16'h0DE1);
    w(8'h00, 16'h8140);
    chk(an, 1'b0);
    rdc(8'h00, 16'h0140);
    w(8'h16, 16'h0000);
    rdc(8'h00, 16'h1140);
    chk(an, 1'b0);
    chk(swn[15:0], 16'h0008);
    // Reset mid-run restores autoneg
    rstn = 1'b0;
    repeat (2) @(negedge clk);
    rstn = 1'b1;
    repeat (3) @(negedge clk);
    chk(an, 1'b1);
    chk(page, 16'h0000);
    rdc(8'h00, 16'h1140);
    close_out;
  end
  // Pulse is one cycle, so each falling edge sees it once
  always @(negedge clk) begin
    if (swr === 1'b1)
      swn = swn + 1;
  end
  // Hang guard well above the expected run
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 60000) begin
      errors = errors + 1;
      close_out;
    end
  end
endmodule // tb_ppmr_paged_phy_mgmt_regs
